/* rtl/dhp_host_port_map.vh */
`ifndef DHP_HOST_PORT_MAP_VH
`define DHP_HOST_PORT_MAP_VH

// ----------------------------------------------------------------
// Address selection (A0 pin)
// ----------------------------------------------------------------
`define DHP_A0_MAIN_STATUS 1'b0
`define DHP_A0_DATA 1'b1

// ----------------------------------------------------------------
// main_status field positions
// ----------------------------------------------------------------
`define DHP_MS_SEEK_LSB 0
`define DHP_MS_SEEK_MSB 3
`define DHP_MS_CMD_IN_PROGRESS 4
`define DHP_MS_EXEC_MODE 5
`define DHP_MS_XFER_DIRECTION 6
`define DHP_MS_HOST_REQUEST 7

// ----------------------------------------------------------------
// rate_control encoding and reset value
// ----------------------------------------------------------------
`define DHP_RATE_500K 2'b00
`define DHP_RATE_250K_300K 2'b01
`define DHP_RATE_250K 2'b10
`define DHP_RATE_125K 2'b11
`define DHP_RATE_RESET 2'b10

// ----------------------------------------------------------------
// Phases
// ----------------------------------------------------------------
`define DHP_PH_CMD 2'b00
`define DHP_PH_EXEC 2'b01
`define DHP_PH_RES 2'b10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DHP_CLK_MHZ 200
`define DHP_SETTLE_US 12
`define DHP_SETTLE_CYCLES (`DHP_SETTLE_US * `DHP_CLK_MHZ)
// Bit periods in 200 MHz clocks, sized for the divider
`define DHP_DIV_500 12'h190
`define DHP_DIV_300 12'h29A
`define DHP_DIV_250 12'h320
`define DHP_DIV_125 12'h640
`define DHP_DIV_BYPASS 12'h040

// ----------------------------------------------------------------
// Pin synchroniser bit positions and idle levels
// ----------------------------------------------------------------
`define DHP_PIN_CS 0
`define DHP_PIN_RD 1
`define DHP_PIN_WR 2
`define DHP_PIN_A0 3
`define DHP_PIN_DACK 4
`define DHP_PIN_TC 5
`define DHP_PIN_LOAD 6
`define DHP_PIN_DRV 7
`define DHP_PIN_IDLE 8'h5F

`endif

/* rtl/dhp_host_port.v */
`timescale 1ns/100ps
`include "dhp_host_port_map.vh"

module dhp_host_port #(
    parameter SETTLE_CYC = `DHP_SETTLE_CYCLES
) (
    input wire clk_sys,
    input wire rst_n,
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire a0,
    input wire dack_n,
    input wire tc,
    input wire rate_reg_load_n,
    input wire drive_type_in,
    input wire [7:0] dataIn,
    output reg [7:0] dataOut,
    output wire dataOe,
    output wire irqOut,
    output wire irqOe,
    output wire drqOut,
    output wire drqOe,
    output wire spindle_speed_sel,
    output wire rate_sel_hi,
    output wire rate_sel_lo,
    output reg bitTick,
    input wire dmaMode,
    input wire atMode,
    input wire outEnable,
    input wire rateRegBypass,
    input wire fmSel,
    input wire [3:0] driveSeekBusy,
    output reg [7:0] cmdByte,
    output reg cmdByteStrobe,
    output reg cmdComplete,
    input wire [3:0] cmdLen,
    input wire execDone,
    input wire [3:0] resLen,
    input wire [7:0] resData,
    output reg [3:0] resIndex,
    input wire toHostValid,
    input wire [7:0] toHostData,
    output reg toHostTaken,
    input wire fromHostReq,
    output reg [7:0] fromHostData,
    output reg fromHostTaken,
    output reg tcAccepted
);

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
wire [7:0] pinRaw;
reg [7:0] pinS1, pinS2, pinS3, pinF, pinP;
reg [7:0] dataS1, dataS2, dataS3, wrLatch;

assign pinRaw = {drive_type_in, rate_reg_load_n, tc, dack_n, a0, wr_n,
    rd_n, cs_n};

// A change counts only once the second and third stages agree
always @(posedge clk_sys) begin
    if (!rst_n) begin
        pinS1 <= `DHP_PIN_IDLE;
        pinS2 <= `DHP_PIN_IDLE;
        pinS3 <= `DHP_PIN_IDLE;
        pinF <= `DHP_PIN_IDLE;
        pinP <= `DHP_PIN_IDLE;
        dataS1 <= 8'h00;
        dataS2 <= 8'h00;
        dataS3 <= 8'h00;
        wrLatch <= 8'h00;
    end else begin
        pinS1 <= pinRaw;
        pinS2 <= pinS1;
        pinS3 <= pinS2;
        pinF <= (pinF & (pinS2 ^ pinS3)) | (pinS3 & ~(pinS2 ^ pinS3));
        pinP <= pinF;
        dataS1 <= dataIn;
        dataS2 <= dataS1;
        dataS3 <= dataS2;
        // Bus data is kept while the write strobe stays low
        if (!pinF[`DHP_PIN_WR])
            wrLatch <= dataS3;
    end
end

// ----------------------------------------------------------------
// Strobe decode
// ----------------------------------------------------------------
wire rdEnd, wrEnd, pioSel, dmaSel, dataSel, rdData, wrData, rateWrite, tcRise;

// Qualifiers are taken from the strobe's low time; hold time is zero
assign rdEnd = !pinP[`DHP_PIN_RD] && pinF[`DHP_PIN_RD];
assign wrEnd = !pinP[`DHP_PIN_WR] && pinF[`DHP_PIN_WR];
assign pioSel = !pinP[`DHP_PIN_CS];
assign dmaSel = !pinP[`DHP_PIN_DACK];
assign dataSel = dmaSel || (pioSel && pinP[`DHP_PIN_A0] == `DHP_A0_DATA);
assign rdData = rdEnd && dataSel;
assign wrData = wrEnd && dataSel && pinP[`DHP_PIN_LOAD];
// rate load only with chip select idle
assign rateWrite = wrEnd && !pinP[`DHP_PIN_LOAD] && !pioSel;
assign tcRise = pinF[`DHP_PIN_TC] && !pinP[`DHP_PIN_TC];

// ----------------------------------------------------------------
// Phase sequencer
// ----------------------------------------------------------------
reg [1:0] phase;
reg [3:0] cmdCount, resTotal;
reg [12:0] settleCnt;
reg cmdCheck, irqFlag, pendPrev;
wire settling, execPend, hostRequest, xferDirection, cmdInProgress, execMode;
wire [3:0] cmdNeed;
wire [7:0] mainStatus;

assign settling = settleCnt != 13'h0000;
assign execPend = phase == `DHP_PH_EXEC && (toHostValid || fromHostReq);
// a zero length from the decoder still counts the code byte
assign cmdNeed = (cmdLen == 4'h0) ? 4'h1 : cmdLen;

always @(posedge clk_sys) begin
    if (!rst_n) begin
        phase <= `DHP_PH_CMD;
        cmdCount <= 4'h0;
        resTotal <= 4'h0;
        resIndex <= 4'h0;
        cmdCheck <= 1'b0;
        settleCnt <= 13'h0000;
        cmdByte <= 8'h00;
        cmdByteStrobe <= 1'b0;
        cmdComplete <= 1'b0;
        fromHostData <= 8'h00;
        fromHostTaken <= 1'b0;
        toHostTaken <= 1'b0;
    end else begin
        cmdByteStrobe <= 1'b0;
        cmdComplete <= 1'b0;
        fromHostTaken <= 1'b0;
        toHostTaken <= 1'b0;
        cmdCheck <= 1'b0;
        if (settling)
            settleCnt <= settleCnt - 13'h0001;
        case (phase)
            `DHP_PH_CMD: begin
                // writes during settling are not taken
                if (wrData && !settling && !cmdCheck) begin
                    cmdByte <= wrLatch;
                    cmdByteStrobe <= 1'b1;
                    cmdCount <= cmdCount + 4'h1;
                    cmdCheck <= 1'b1;
                    // request drops, then returns after settling
                    settleCnt <= SETTLE_CYC[12:0];
                end
                // decoder length is valid one cycle after the byte
                if (cmdCheck && cmdCount >= cmdNeed) begin
                    cmdCount <= 4'h0;
                    cmdComplete <= 1'b1;
                    settleCnt <= 13'h0000;
                    phase <= `DHP_PH_EXEC;
                end
            end
            `DHP_PH_EXEC: begin
                if (rdData && toHostValid)
                    toHostTaken <= 1'b1;
                if (wrData && fromHostReq) begin
                    fromHostData <= wrLatch;
                    fromHostTaken <= 1'b1;
                end
                if (execDone) begin
                    resIndex <= 4'h0;
                    resTotal <= resLen;
                    phase <= (resLen == 4'h0) ? `DHP_PH_CMD : `DHP_PH_RES;
                end
            end
            `DHP_PH_RES: begin
                // every result byte read before a new command
                if (rdData && !settling) begin
                    resIndex <= resIndex + 4'h1;
                    // busy clears after the same settling time
                    settleCnt <= SETTLE_CYC[12:0];
                    if (resIndex + 4'h1 >= resTotal)
                        phase <= `DHP_PH_CMD;
                end
            end
            default: phase <= `DHP_PH_CMD;
        endcase
    end
end

// ----------------------------------------------------------------
// Main status
// ----------------------------------------------------------------
// request held low while the byte settles
// bit 7 ready, bit 6 direction
assign hostRequest = (phase == `DHP_PH_EXEC) ? (execPend && !dmaMode) :
    (!settling && !cmdCheck);
assign xferDirection = (phase == `DHP_PH_RES) ||
    (phase == `DHP_PH_EXEC && toHostValid);
assign cmdInProgress = phase != `DHP_PH_CMD || cmdCount != 4'h0 ||
    settling;
assign execMode = phase == `DHP_PH_EXEC && !dmaMode;
assign mainStatus = {hostRequest, xferDirection, execMode, cmdInProgress,
    driveSeekBusy};

// status read has no side effect on the sequencer
always @(posedge clk_sys) begin
    if (!rst_n) begin
        dataOut <= 8'h00;
    end else if (pinF[`DHP_PIN_A0] == `DHP_A0_DATA ||
            !pinF[`DHP_PIN_DACK]) begin
        if (phase == `DHP_PH_RES)
            dataOut <= resData;
        else if (phase == `DHP_PH_EXEC)
            dataOut <= toHostData;
        else
            dataOut <= 8'h00;
    end else begin
        dataOut <= mainStatus;
    end
end

assign dataOe = !pinF[`DHP_PIN_RD] &&
    (!pinF[`DHP_PIN_CS] || !pinF[`DHP_PIN_DACK]);

// ----------------------------------------------------------------
// Interrupt, DMA request and terminal count
// ----------------------------------------------------------------
wire irqSet, irqClr;

// one interrupt per pending execution byte in non-DMA mode
// result phase start raises it in either mode
assign irqSet = (execPend && !pendPrev && !dmaMode) ||
    (phase == `DHP_PH_EXEC && execDone && resLen != 4'h0);
// read clears; write clears in execution phase only; first result read clears
assign irqClr = rdData || (wrData && phase == `DHP_PH_EXEC);

always @(posedge clk_sys) begin
    if (!rst_n) begin
        irqFlag <= 1'b0;
        pendPrev <= 1'b0;
        tcAccepted <= 1'b0;
    end else begin
        pendPrev <= execPend;
        // Set wins over a clear in the same cycle
        if (irqSet)
            irqFlag <= 1'b1;
        else if (irqClr)
            irqFlag <= 1'b0;
        // AT mode needs acknowledge with terminal count
        tcAccepted <= tcRise && (!atMode || !pinF[`DHP_PIN_DACK]);
    end
end

assign irqOut = irqFlag;
// Request drops as soon as the acknowledge arrives
assign drqOut = dmaMode && execPend && pinF[`DHP_PIN_DACK];
// output enables gated in AT mode only
assign irqOe = atMode ? outEnable : 1'b1;
assign drqOe = atMode ? outEnable : 1'b1;

// ----------------------------------------------------------------
// Rate control and bit clock divider
// ----------------------------------------------------------------
reg [1:0] rateSel;
reg [11:0] divCnt, divActive, next_div;

always @(posedge clk_sys) begin
    if (!rst_n)
        rateSel <= `DHP_RATE_RESET;
    else if (rateWrite)
        rateSel <= wrLatch[1:0];
end

// rate table; FM halves the MFM rate
// bypass divides the system clock by 64
always @* begin
    next_div = `DHP_DIV_250;
    case (rateSel)
        `DHP_RATE_500K: next_div = `DHP_DIV_500;
        `DHP_RATE_250K_300K: next_div = pinF[`DHP_PIN_DRV] ?
            `DHP_DIV_300 : `DHP_DIV_250;
        `DHP_RATE_250K: next_div = `DHP_DIV_250;
        `DHP_RATE_125K: next_div = `DHP_DIV_125;
        default: next_div = `DHP_DIV_250;
    endcase
    if (fmSel)
        next_div = {next_div[10:0], 1'b0};
    if (rateRegBypass)
        next_div = `DHP_DIV_BYPASS;
end

// new divisor only at a period boundary, so no short tick
always @(posedge clk_sys) begin
    if (!rst_n) begin
        divCnt <= 12'h000;
        divActive <= `DHP_DIV_250;
        bitTick <= 1'b0;
    end else if (divCnt >= divActive - 12'h001) begin
        divCnt <= 12'h000;
        divActive <= next_div;
        bitTick <= 1'b1;
    end else begin
        divCnt <= divCnt + 12'h001;
        bitTick <= 1'b0;
    end
end

// spindle speed follows the rate code
assign spindle_speed_sel = ~rateSel[0];
assign rate_sel_hi = rateSel[1];
assign rate_sel_lo = rateSel[0];

endmodule // dhp_host_port

/* verification/dhp_host_port_props.sv */
`timescale 1ns/100ps
module dhp_host_port_props (
    input logic clk_sys,
    input logic rst_n,
    input logic cs_n,
    input logic rd_n,
    input logic dack_n,
    input logic dmaMode,
    input logic atMode,
    input logic outEnable,
    input logic execDone,
    input logic dataOe,
    input logic irqOut,
    input logic irqOe,
    input logic drqOe,
    input logic spindle_speed_sel,
    input logic rate_sel_hi,
    input logic rate_sel_lo,
    input logic toHostTaken,
    input logic fromHostTaken,
    input logic [3:0] resIndex,
    input logic tcAccepted
);
    logic [3:0] noDackRun;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Run of cycles with terminal count unqualified
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !atMode || !dack_n)
            noDackRun <= 4'h0;
        else if (noDackRun != 4'hF)
            noDackRun <= noDackRun + 4'h1;
    end

    rate_reset_a: assert property (
        $rose(rst_n) |-> {rate_sel_hi, rate_sel_lo} == 2'b10)
        else $error("rate reset");
    spindle_map_a: assert property (
        spindle_speed_sel == !rate_sel_lo) else $error("spindle");
    bus_drive_a: assert property (
        (!rd_n && !cs_n)[*5] |-> dataOe) else $error("bus drive");
    exec_rd_a: assert property (
        toHostTaken && !dmaMode |-> ##[1:2] !irqOut)
        else $error("read irq");
    exec_wr_a: assert property (
        fromHostTaken && !dmaMode |-> ##[1:2] !irqOut)
        else $error("write irq");
    dma_irq_a: assert property (
        dmaMode && $rose(irqOut) |-> $past(execDone) || $past(execDone, 2))
        else $error("dma irq");
    res_clear_a: assert property (
        resIndex == $past(resIndex) + 4'h1 |=> !irqOut)
        else $error("result irq");
    oe_gate_a: assert property (
        atMode && !outEnable |-> !irqOe && !drqOe) else $error("oe gate");
    tc_qual_a: assert property (
        tcAccepted |-> noDackRun < 4'h8) else $error("tc qual");

    cover property (dmaMode && $rose(irqOut));
    cover property (fromHostTaken);
    cover property (tcAccepted);
endmodule // dhp_host_port_props

bind dhp_host_port dhp_host_port_props u_props (.clk_sys(clk_sys),
    .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .dack_n(dack_n),
    .dmaMode(dmaMode), .atMode(atMode), .outEnable(outEnable),
    .execDone(execDone), .dataOe(dataOe), .irqOut(irqOut),
    .irqOe(irqOe), .drqOe(drqOe), .spindle_speed_sel(spindle_speed_sel),
    .rate_sel_hi(rate_sel_hi), .rate_sel_lo(rate_sel_lo),
    .toHostTaken(toHostTaken), .fromHostTaken(fromHostTaken),
    .resIndex(resIndex), .tcAccepted(tcAccepted));

/* verification/dhp_host_model.sv */
`timescale 1ns/100ps
module dhp_host_model (
    input logic clk_sys,
    input logic [7:0] dataOut,
    input logic dataOe,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic a0,
    output logic dack_n,
    output logic loadN,
    output logic [7:0] dataIn
);
    logic [7:0] hostD;
    logic hostOe;
    initial begin
        {cs_n, rd_n, wr_n, dack_n, loadN, hostOe} = 6'h3E;
        a0 = 1'b0;
        hostD = 8'h00;
    end
    // Released bus shows inverse, never a stale copy
    assign dataIn = dataOe ? dataOut : hostOe ? hostD : ~hostD;

    // m: 0 chip select, 1 acknowledge, 2 rate load
    // qualifiers held over strobe
    task xfer(input logic w, input logic a, input logic [1:0] m,
              input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_sys);
        #1;
        a0 = a;
        cs_n = m != 2'h0;
        dack_n = m != 2'h1;
        loadN = m != 2'h2;
        hostD = d;
        hostOe = w;
        rd_n = w;
        wr_n = !w;
        repeat (6) @(posedge clk_sys);
        #1;
        q = dataIn;
        rd_n = 1'b1;
        wr_n = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        {cs_n, dack_n, loadN, hostOe} = 4'hE;
    endtask
endmodule // dhp_host_model

/* verification/disk_ctrl_host_port_bench.sv */
`timescale 1ns/100ps
module disk_ctrl_host_port_bench;
    logic clk_sys, rst_n, tc, driveType, dmaMode, atMode, outEnable;
    logic bypass, fmSel, execDone, toHostValid, fromHostReq;
    logic [7:0] q;
    logic [15:0] strobes, tcs, dones;
    wire cs_n, rd_n, wr_n, a0, dack_n, loadN, dataOe, irqOut, drqOut;
    wire spindle, rateHi, rateLo, bitTick, cmdByteStrobe, cmdComplete;
    wire toHostTaken, fromHostTaken, tcAccepted, irqOe, drqOe;
    wire [7:0] dataIn, dataOut, cmdByte, fromHostData;
    wire [3:0] resIndex;
    int errorCnt, samplesChecked, cycles;

    dhp_host_model u_host (.clk_sys(clk_sys), .dataOut(dataOut),
        .dataOe(dataOe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a0(a0),
        .dack_n(dack_n), .loadN(loadN), .dataIn(dataIn));

    // Short settle keeps the run brief
    dhp_host_port #(.SETTLE_CYC(8)) u_dhp_host_port (.clk_sys(clk_sys),
        .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a0(a0),
        .dack_n(dack_n), .tc(tc), .rate_reg_load_n(loadN),
        .drive_type_in(driveType), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .irqOut(irqOut), .irqOe(irqOe), .drqOut(drqOut),
        .drqOe(drqOe), .spindle_speed_sel(spindle), .rate_sel_hi(rateHi),
        .rate_sel_lo(rateLo), .bitTick(bitTick), .dmaMode(dmaMode),
        .atMode(atMode), .outEnable(outEnable), .rateRegBypass(bypass),
        .fmSel(fmSel), .driveSeekBusy(4'h0), .cmdByte(cmdByte),
        .cmdByteStrobe(cmdByteStrobe), .cmdComplete(cmdComplete),
        .cmdLen(4'h2),
        .execDone(execDone), .resLen(4'h2), .resData({4'hA, resIndex}),
        .resIndex(resIndex), .toHostValid(toHostValid),
        .toHostData(8'h5A), .toHostTaken(toHostTaken),
        .fromHostReq(fromHostReq), .fromHostData(fromHostData),
        .fromHostTaken(fromHostTaken), .tcAccepted(tcAccepted));

    always #2.5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cycles++;
        if (toHostTaken)
            toHostValid <= 1'b0;
        if (fromHostTaken)
            fromHostReq <= 1'b0;
        if (cmdByteStrobe)
            strobes++;
        if (cmdComplete)
            dones++;
        if (tcAccepted)
            tcs++;
        if (cycles == 30000) begin
            errorCnt++;
            finalReport();
        end
    end

    task chk(input string nm, input logic [15:0] seen, exp);
        samplesChecked++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task poll(input logic [7:0] exp);
        logic [7:0] s;
        int k;
        k = 0;
        do begin
            u_host.xfer(1'b0, 1'b0, 2'h0, 8'h00, s);
            k++;
        end while (s[7] !== 1'b1 && k < 8);
        chk("status", s, exp);
    endtask

    task ex(input logic w, input logic dma);
        // Let the previous byte's request drop first
        @(posedge clk_sys);
        #1;
        if (w)
            fromHostReq = 1'b1;
        else
            toHostValid = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk("irq set", irqOut, !dma);
        chk("drq set", drqOut, dma);
        u_host.xfer(w, 1'b1, {1'b0, dma}, 8'hC3, q);
        chk("irq clr", irqOut, 1'b0);
        chk("xfer", w ? fromHostData : q, w ? 8'hC3 : 8'h5A);
    endtask

    task run(input logic dma);
        logic [15:0] n;
        dmaMode = dma;
        poll(8'h80);
        u_host.xfer(1'b1, 1'b1, 2'h0, 8'h46, q);
        chk("cmd0", cmdByte, 8'h46);
        poll(8'h90);
        u_host.xfer(1'b1, 1'b1, 2'h0, 8'h07, q);
        chk("cmd1", cmdByte, 8'h07);
        ex(1'b0, dma);
        ex(1'b1, dma);
        execDone = 1'b1;
        @(posedge clk_sys);
        #1;
        execDone = 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("irq res", irqOut, 1'b1);
        poll(8'hD0);
        n = strobes;
        u_host.xfer(1'b1, 1'b1, 2'h0, 8'h0F, q);
        chk("refused", strobes, n);
        chk("irq hold", irqOut, 1'b1);
        for (int i = 0; i < 2; i++) begin
            poll(8'hD0);
            u_host.xfer(1'b0, 1'b1, 2'h0, 8'h00, q);
            chk("result", q, 8'hA0 | 8'(i));
            chk("irq", irqOut, 1'b0);
        end
        poll(8'h80);
    endtask

    task per(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] n;
        u_host.xfer(1'b1, 1'b0, 2'h2, 8'hFC | code, q);
        for (int k = 0; k < 3; k++) begin
            n = 16'h0;
            do begin
                @(posedge clk_sys);
                #1;
                n++;
            end while (bitTick !== 1'b1 && n < 16'h1000);
        end
        chk("period", n, exp);
    endtask

    task finalReport;
        $display("checks %0d errors %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        {clk_sys, rst_n, tc, driveType, dmaMode, atMode} = 6'h0;
        {execDone, toHostValid, fromHostReq, bypass, fmSel} = 5'h0;
        {strobes, tcs, dones} = 48'h0;
        outEnable = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        repeat (6) @(posedge clk_sys);
        chk("rate rst", {rateHi, rateLo, spindle}, 3'b101);
        run(1'b0);
        run(1'b1);
        chk("cmd done", dones, 16'h2);
        for (int c = 0; c < 4; c++) begin
            u_host.xfer(1'b1, 1'b0, 2'h2, 8'hFC | 8'(c), q);
            chk("rate", {rateHi, rateLo, spindle}, {c[1:0], !c[0]});
        end
        driveType = 1'b1;
        per(8'h01, 16'd666);
        per(8'h00, 16'd400);
        fmSel = 1'b1;
        per(8'h00, 16'd800);
        fmSel = 1'b0;
        bypass = 1'b1;
        per(8'h00, 16'd64);
        for (int p = 0; p < 2; p++) begin
            atMode = !p[0];
            outEnable = p[0];
            repeat (10) @(posedge clk_sys);
            #1;
            chk("oe", {irqOe, drqOe}, {p[0], p[0]});
            tc = 1'b1;
            repeat (6) @(posedge clk_sys);
            #1;
            tc = 1'b0;
            repeat (8) @(posedge clk_sys);
            chk("tc", tcs, 16'(p));
        end
        finalReport();
    end
endmodule // disk_ctrl_host_port_bench
